// ---- glds_pkg.sv ----
// Constants for the low pin-group direction and source-select block.
// Assumes a 32-bit register port with byte addresses in 12 bits.
`default_nettype none

package glds_pkg;

    localparam int unsigned GLDS_ADDR_W = 12;
    localparam int unsigned GLDS_DATA_W = 32;
    // Widest pin count that one control word can serve
    localparam int unsigned GLDS_PIN_MAX = 16;
    // Default pin count; pin 15 lies outside this block
    localparam int unsigned GLDS_PIN_DEF = 15;

    localparam logic [11:0] GLDS_OFF_CTRL = 12'h62c;
    localparam logic [11:0] GLDS_OFF_IN_DATA = 12'h63c;
    localparam logic [11:0] GLDS_OFF_OUT_DATA = 12'h644;

    localparam logic [31:0] GLDS_RST_CTRL = 32'h0000_0000;
    localparam logic [31:0] GLDS_RST_OUT_DATA = 32'h0000_0000;
    localparam logic [31:0] GLDS_RD_ZERO = 32'h0000_0000;

    // Position of each field inside a pin's bit pair
    localparam int unsigned GLDS_SEL_POS = 0;
    localparam int unsigned GLDS_DIR_POS = 1;
    localparam int unsigned GLDS_BITS_PER_PIN = 2;

    localparam logic GLDS_DIR_IN = 1'b0;
    localparam logic GLDS_DIR_OUT = 1'b1;
    localparam logic GLDS_SEL_REG = 1'b0;
    localparam logic GLDS_SEL_ALT = 1'b1;

    // Bit index of a field of pin n in the control word
    function automatic int unsigned glds_field_pos(input int unsigned pin,
                                                   input int unsigned field);
        return pin * GLDS_BITS_PER_PIN + field;
    endfunction

endpackage : glds_pkg

`default_nettype wire

// ---- glds_pin_cell.sv ----
// One pin's path: direction, source and destination steering.
// Assumes its controls come from registers in the same clock domain.
`timescale 1ns/100ps
`default_nettype none

module glds_pin_cell (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic dir_i,
    input wire logic sel_i,
    input wire logic out_data_i,
    input wire logic slot_reset_n_i,
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe_n_o,
    output logic in_level_o,
    output logic int_src_o
);
    import glds_pkg::*;

    typedef struct packed {
        logic pin_out;
        logic oe_n;
        logic in_level;
        logic int_src;
    } glds_cell_s;

    glds_cell_s state;
    glds_cell_s next_state;

    always_comb begin
        next_state = state;
        next_state.oe_n = (dir_i == GLDS_DIR_OUT) ? 1'b0 : 1'b1;
        next_state.pin_out = 1'b0;
        next_state.in_level = 1'b0;
        next_state.int_src = 1'b0;
        if (dir_i == GLDS_DIR_OUT) begin
            next_state.pin_out = (sel_i == GLDS_SEL_REG) ? out_data_i : slot_reset_n_i;
        end else if (sel_i == GLDS_SEL_REG) begin
            next_state.in_level = pin_i;
        end else begin
            next_state.int_src = pin_i;
        end
    end

    // One registered step, no decode glitch
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= '{pin_out: 1'b0, oe_n: 1'b1, in_level: 1'b0, int_src: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign pin_o = state.pin_out;
    assign pin_oe_n_o = state.oe_n;
    assign in_level_o = state.in_level;
    assign int_src_o = state.int_src;

    drive_enable_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rst_n_i |=> (pin_oe_n_o == !$past(dir_i)))
        else $error("Pin enable does not follow direction");

    drive_data_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rst_n_i && dir_i && !sel_i) |=> (pin_o == $past(out_data_i)) && !pin_oe_n_o)
        else $error("Pin not driven from output data");

    drive_reset_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rst_n_i && dir_i && sel_i) |=> (pin_o == $past(slot_reset_n_i)) && !pin_oe_n_o)
        else $error("Pin not driven from slot reset");

    sample_input_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rst_n_i && !dir_i && !sel_i) |=> (in_level_o == $past(pin_i)) && !int_src_o)
        else $error("Input level not sampled");

    route_int_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rst_n_i && !dir_i && sel_i) |=> (int_src_o == $past(pin_i)) && !in_level_o
            && pin_oe_n_o)
        else $error("Input not routed to interrupt path");

endmodule // glds_pin_cell

`default_nettype wire

// ---- glds_top.sv ----
// Top of the low pin-group direction block with its register port.
// Assumes a master that never strobes read and write together.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module glds_top #(
    parameter int unsigned PIN_COUNT = glds_pkg::GLDS_PIN_DEF
) (
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    input wire logic [glds_pkg::GLDS_ADDR_W-1:0] ADDR_I,
    input wire logic [glds_pkg::GLDS_DATA_W-1:0] WR_DATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [glds_pkg::GLDS_DATA_W-1:0] RD_DATA_O,
    input wire logic [PIN_COUNT-1:0] PIN_I,
    output logic [PIN_COUNT-1:0] PIN_O,
    output logic [PIN_COUNT-1:0] PIN_OE_N_O,
    input wire logic [PIN_COUNT-1:0] SLOT_RESET_N_I,
    output logic [PIN_COUNT-1:0] INT_SRC_O
);
    import glds_pkg::*;

    // Pin 15 needs a slot reset that is not present, so the cap is one short
    if (PIN_COUNT < 1 || PIN_COUNT > GLDS_PIN_MAX - 1) begin : g_bad_count
        $error("PIN_COUNT must lie between 1 and 15");
    end

    typedef struct packed {
        logic [GLDS_DATA_W-1:0] ctrl;
        logic [PIN_COUNT-1:0] out_data;
        logic [GLDS_DATA_W-1:0] rd_data;
    } glds_regs_s;

    glds_regs_s regs;
    glds_regs_s next_regs;

    logic [PIN_COUNT-1:0] dir_vec;
    logic [PIN_COUNT-1:0] sel_vec;
    logic [PIN_COUNT-1:0] in_level_vec;

    // Bits of unserved pins stay zero so reads never show dead controls
    function automatic logic [GLDS_DATA_W-1:0] ctrl_mask();
        logic [GLDS_DATA_W-1:0] m;
        m = GLDS_RD_ZERO;
        for (int unsigned i = 0; i < PIN_COUNT; i++) begin
            m[glds_field_pos(i, GLDS_SEL_POS)] = 1'b1;
            m[glds_field_pos(i, GLDS_DIR_POS)] = 1'b1;
        end
        return m;
    endfunction

    localparam logic [GLDS_DATA_W-1:0] CTRL_MASK = ctrl_mask();

    always_comb begin
        next_regs = regs;
        next_regs.rd_data = GLDS_RD_ZERO;
        if (WR_I) begin
            unique case (ADDR_I)
                GLDS_OFF_CTRL: begin
                    next_regs.ctrl = WR_DATA_I & CTRL_MASK;
                end
                GLDS_OFF_OUT_DATA: begin
                    next_regs.out_data = WR_DATA_I[PIN_COUNT-1:0];
                end
                default: begin
                    next_regs.ctrl = regs.ctrl;
                end
            endcase
        end
        if (RD_I) begin
            unique case (ADDR_I)
                GLDS_OFF_CTRL: begin
                    next_regs.rd_data = regs.ctrl;
                end
                GLDS_OFF_IN_DATA: begin
                    next_regs.rd_data = GLDS_DATA_W'(in_level_vec);
                end
                GLDS_OFF_OUT_DATA: begin
                    next_regs.rd_data = GLDS_DATA_W'(regs.out_data);
                end
                default: begin
                    next_regs.rd_data = GLDS_RD_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            regs.ctrl <= GLDS_RST_CTRL;
            regs.out_data <= GLDS_RST_OUT_DATA[PIN_COUNT-1:0];
            regs.rd_data <= GLDS_RD_ZERO;
        end else begin
            regs <= next_regs;
        end
    end

    assign RD_DATA_O = regs.rd_data;

    // Split control word into pin pairs
    always_comb begin
        for (int unsigned i = 0; i < PIN_COUNT; i++) begin
            sel_vec[i] = regs.ctrl[glds_field_pos(i, GLDS_SEL_POS)];
            dir_vec[i] = regs.ctrl[glds_field_pos(i, GLDS_DIR_POS)];
        end
    end

    for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
        glds_pin_cell u_cell (
            .clk_i(CLK_SYS_I),
            .rst_n_i(RST_N_I),
            .dir_i(dir_vec[g]),
            .sel_i(sel_vec[g]),
            .out_data_i(regs.out_data[g]),
            .slot_reset_n_i(SLOT_RESET_N_I[g]),
            .pin_i(PIN_I[g]),
            .pin_o(PIN_O[g]),
            .pin_oe_n_o(PIN_OE_N_O[g]),
            .in_level_o(in_level_vec[g]),
            .int_src_o(INT_SRC_O[g])
        );
    end

    ctrl_write_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (WR_I && ADDR_I == GLDS_OFF_CTRL) |=> (regs.ctrl == ($past(WR_DATA_I) & CTRL_MASK)))
        else $error("Control word not written");

    ctrl_read_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (RD_I && ADDR_I == GLDS_OFF_CTRL && !WR_I) |=> (RD_DATA_O == $past(regs.ctrl)))
        else $error("Control word readback wrong");

    unmapped_read_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (RD_I && ADDR_I != GLDS_OFF_CTRL && ADDR_I != GLDS_OFF_IN_DATA
            && ADDR_I != GLDS_OFF_OUT_DATA) |=> (RD_DATA_O == GLDS_RD_ZERO))
        else $error("Unmapped read not zero");

    write_to_pin_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (WR_I && ADDR_I == GLDS_OFF_CTRL && WR_DATA_I[GLDS_DIR_POS])
            |=> ##1 !PIN_OE_N_O[0])
        else $error("Direction change not on pin one cycle later");

    idle_pin_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (!WR_I && $stable(regs.ctrl) && $stable(regs.out_data) && !dir_vec[0])
            |=> $stable(PIN_OE_N_O[0]))
        else $error("Pin enable moved without a write");

    in_data_read_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (RD_I && ADDR_I == GLDS_OFF_IN_DATA) |=> (RD_DATA_O[0] == $past(in_level_vec[0])))
        else $error("Input data readback wrong");

    // Register port checks
    rd_idle_zero_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        !RD_I |=> (RD_DATA_O == GLDS_RD_ZERO))
        else $error("Read data not zero outside a read");

    out_data_write_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (WR_I && ADDR_I == GLDS_OFF_OUT_DATA) |=> (regs.out_data == PIN_COUNT'($past(WR_DATA_I))))
        else $error("Output data not written");

    out_data_read_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (RD_I && ADDR_I == GLDS_OFF_OUT_DATA) |=> (RD_DATA_O == GLDS_DATA_W'($past(regs.out_data))))
        else $error("Output data readback wrong");

    in_data_full_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (RD_I && ADDR_I == GLDS_OFF_IN_DATA) |=> (RD_DATA_O == GLDS_DATA_W'($past(in_level_vec))))
        else $error("Input data word wrong");

    ctrl_unserved_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        ((regs.ctrl & ~CTRL_MASK) == GLDS_RD_ZERO))
        else $error("Control bit of an unserved pin set");

    ctrl_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        !(WR_I && ADDR_I == GLDS_OFF_CTRL) |=> $stable(regs.ctrl))
        else $error("Control word moved without a write");

    out_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        !(WR_I && ADDR_I == GLDS_OFF_OUT_DATA) |=> $stable(regs.out_data))
        else $error("Output data moved without a write");

    // No disable here: this one watches the reset itself
    reset_clear_a: assert property (@(posedge CLK_SYS_I)
        !RST_N_I |=> (regs.ctrl == GLDS_RST_CTRL) && (RD_DATA_O == GLDS_RD_ZERO)
            && (&PIN_OE_N_O) && (PIN_O == '0) && (INT_SRC_O == '0))
        else $error("Reset values not held");

    // Pin checks; pin 0 stands for all except in pin_enable_all_a, the cells being identical copies
    write_release_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (WR_I && ADDR_I == GLDS_OFF_CTRL && !WR_DATA_I[GLDS_DIR_POS])
            |=> ##1 PIN_OE_N_O[0])
        else $error("Pin release not on pin one cycle later");

    pin_enable_all_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        RST_N_I |=> (PIN_OE_N_O == ~$past(dir_vec)))
        else $error("Pin enables do not follow directions");

    pin_idle_low_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        !dir_vec[0] |=> (!PIN_O[0] && PIN_OE_N_O[0]))
        else $error("Input pin still driven");

    in_level_zero_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (dir_vec[0] || sel_vec[0]) |=> !in_level_vec[0])
        else $error("Input data bit set for a pin not sampled");

    int_src_idle_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (dir_vec[0] || !sel_vec[0]) |=> !INT_SRC_O[0])
        else $error("Interrupt source set for a pin not routed");

endmodule // glds_top

`default_nettype wire

// ---- glds_board.sv ----
// Board side model: weak board levels on the pins, slot reset lines.
// Assumes the block's drive enables are active low, one per pin.
`timescale 1ns/100ps
`default_nettype none

module glds_board #(
    parameter int unsigned N = 15
) (
    input wire logic [N-1:0] drv_i,
    input wire logic [N-1:0] oe_n_i,
    input wire logic [N-1:0] board_i,
    input wire logic [N-1:0] slot_i,
    output logic [N-1:0] lvl_o,
    output logic [N-1:0] slot_n_o
);
    // Block drive wins; released pins show the board level
    assign lvl_o = (~oe_n_i & drv_i) | (oe_n_i & board_i);
    assign slot_n_o = slot_i;
endmodule // glds_board

`default_nettype wire

// ---- glds_top_tb.sv ----
// Self-checking bench for the low pin-group direction block.
// Assumes one clock, register port with read data one cycle later.
`timescale 1ns/100ps
`default_nettype none

module glds_top_tb;
    import glds_pkg::*;
    localparam int unsigned N = 15;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [N-1:0] pin_in, pin_out, oe_n, slot_n, int_src, e_out, e_oe, e_int, e_in;
    logic [N-1:0] board = 15'h6b3d;
    logic [N-1:0] slot = 15'h1e87;
    logic [N-1:0] odata = 15'h5a5a;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;

    always #10 clk = ~clk;

    glds_top #(.PIN_COUNT(N)) dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .ADDR_I(addr),
        .WR_DATA_I(wdata), .WR_I(wr), .RD_I(rd), .RD_DATA_O(rdata), .PIN_I(pin_in),
        .PIN_O(pin_out), .PIN_OE_N_O(oe_n), .SLOT_RESET_N_I(slot_n), .INT_SRC_O(int_src));

    glds_board #(.N(N)) board_m (.drv_i(pin_out), .oe_n_i(oe_n), .board_i(board),
        .slot_i(slot), .lvl_o(pin_in), .slot_n_o(slot_n));

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        cmp(what, exp, rdata);
    endtask

    task automatic pins(input logic [N-1:0] o, input logic [N-1:0] oe, input logic [N-1:0] i);
        cmp("pin out", {17'h0, o}, {17'h0, pin_out});
        cmp("pin enable", {17'h0, oe}, {17'h0, oe_n});
        cmp("interrupt source", {17'h0, i}, {17'h0, int_src});
    endtask

    task automatic final_report;
        $display("Checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Hang guard, far above the roughly 60 cycles the run needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            final_report();
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk("control", GLDS_OFF_CTRL, 32'h0);
        pins(15'h0, 15'h7fff, 15'h0);
        rd_chk("input data", GLDS_OFF_IN_DATA, {17'h0, board});
        // Read-only and unmapped places must not take writes
        wr_reg(GLDS_OFF_IN_DATA, 32'hffff_ffff);
        wr_reg(12'h100, 32'hffff_ffff);
        rd_chk("unmapped", 12'h100, 32'h0);
        rd_chk("input data", GLDS_OFF_IN_DATA, {17'h0, board});
        wr_reg(GLDS_OFF_OUT_DATA, 32'hffff_5a5a);
        rd_chk("output data", GLDS_OFF_OUT_DATA, 32'h0000_5a5a);
        wr_reg(GLDS_OFF_CTRL, 32'h2aaa_aaaa);
        #1;
        pins(15'h0, 15'h7fff, 15'h0);
        @(posedge clk);
        #1;
        pins(15'h5a5a, 15'h0, 15'h0);
        wr_reg(GLDS_OFF_CTRL, 32'hffff_ffff);
        rd_chk("control", GLDS_OFF_CTRL, 32'h3fff_ffff);
        pins(slot, 15'h0, 15'h0);
        slot <= 15'h6178;
        @(posedge clk);
        #1;
        pins(15'h6178, 15'h0, 15'h0);
        // Pin n mode n%4 covers every direction and select pair
        for (int n = 0; n < N; n++) begin
            e_in[n] = (n % 4 == 0) ? board[n] : 1'b0;
            e_int[n] = (n % 4 == 1) ? board[n] : 1'b0;
            e_oe[n] = (n % 4 < 2);
            e_out[n] = (n % 4 == 2) ? odata[n] : 1'b0;
            if (n % 4 == 3) begin
                e_out[n] = slot[n];
            end
        end
        wr_reg(GLDS_OFF_CTRL, 32'h24e4_e4e4);
        // A just released pin still shows its driven level at the next edge
        repeat (2) @(posedge clk);
        #1;
        pins(e_out, e_oe, e_int);
        rd_chk("input data", GLDS_OFF_IN_DATA, {17'h0, e_in});
        // Mid-run reset must clear both words and release every pin
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        pins(15'h0, 15'h7fff, 15'h0);
        rd_chk("control", GLDS_OFF_CTRL, 32'h0);
        rd_chk("output data", GLDS_OFF_OUT_DATA, 32'h0);
        final_report();
    end
endmodule // glds_top_tb

`default_nettype wire
